/* File: eeprom_serial_pkg.sv */
// Purpose: Shared constants and types for the two-wire memory port and its bus master.
// Assumes: Both ends run on one 100 MHz system clock and meet through two_wire_if.
// Notes: Times are counted in system clock cycles.
// Behaviour
// - Device is slave; master supplies every clock.
// - Start: data falls while clock high.
// - Ignore bus until Start, except during write.
// - Stop: data rises while clock high; standby.
// - Receiver pulls data low in ninth slot.
// - Sample on clock rise; change while low.
// - Block radio side while serial operation runs.
// - Start to first rise too long: reset.
// - Clock phase too long: reset until Start.
// - Select byte MSB first: type, enables.
// - Select bit zero: one reads, zero writes.
// - Ack matching select; mismatch means standby.
// - Two acked address bytes, high first.
// - Locked sector without key: no store, NoAck.
// - Only tenth-slot Stop starts write cycle.
// - After write, address follows last byte.
// - During write cycle ignore bus entirely.
// - Page of four bytes; counter advances.
// - Master avoids rolling over the row.
// - Page bytes acked only when unlocked.
// - Sequential read starts like other reads.
// - Upper enable bit selects system area.
// - Master NoAck in read: standby.
package eeprom_serial_pkg;
  localparam int MEM_AW_DEF = 13;
  localparam int ADR_W = 16;
  localparam int PAGE_W = 2;
  localparam int SECT_N = 64;
  localparam int SECT_LSB = 7;
  localparam int SECT_W = 6;
  // Arbitrary device type code, chosen only to be neutral.
  localparam logic [3:0] DEV_TYPE_DEF = 4'h6;
  localparam logic [1:0] CE_FIXED = 2'h3;
  localparam int SEL_RW = 0;
  localparam int SEL_CE_LSB = 1;
  localparam int SEL_UPCE = 3;
  localparam int SEL_TYPE_LSB = 4;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_SLOT = 4'h9;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam int CNT_W = 16;
  localparam int START_TMO_DEF = 1000;
  localparam int CLK_TMO_DEF = 1000;
  localparam int WCYC_DEF = 2000;
  localparam int QUARTER_DEF = 2;
  localparam int WB_AW = 4;
  localparam logic [WB_AW-1:0] WB_CMD = 4'h0;
  localparam logic [WB_AW-1:0] WB_STAT = 4'h4;
  localparam logic [2:0] CMD_START = 3'h1;
  localparam logic [2:0] CMD_STOP = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h4;
  localparam int CMD_OP_LSB = 8;
  localparam int CMD_NACK = 11;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACK = 1;
  localparam int STAT_RX_LSB = 8;
  typedef enum logic [2:0] {S_IDLE, S_SEL, S_AH, S_AL, S_WD, S_RD, S_WCYC} slot_e;
  typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BIT} hstate_e;
endpackage

/* File: two_wire_if.sv */
// Purpose: Open-drain two-wire link between the bus master and the memory port.
// Assumes: An enabled driver pulls its line to its output level; released lines float high.
// Notes: The wired levels are resolved here so design files hold no tristate.
`timescale 1ns/1ns
`default_nettype none
interface two_wire_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);
  modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                  input sda);
  modport slave (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface
`default_nettype wire

/* File: eeprom_serial_slave_port.sv */
// Purpose: Slave end of the two-wire link with byte and page writes into local memory.
// Assumes: The master keeps the bus timing; both lines are asynchronous to clk_i.
// Notes: The system area selected by the upper enable bit is not stored here.
`timescale 1ns/1ns
`default_nettype none
module eeprom_serial_slave_port
  import eeprom_serial_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEF,
  parameter int MEM_AW = MEM_AW_DEF,
  parameter int START_TMO = START_TMO_DEF,
  parameter int CLK_TMO = CLK_TMO_DEF,
  parameter int WCYC = WCYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  two_wire_if.slave bus,
  input wire logic [SECT_N-1:0] sector_lock_i,
  input wire logic key_ok_i,
  output logic rf_block_o,
  output logic wip_o
);
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_s;
  logic sda_s;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;
  slot_e slot_r;
  logic [3:0] bitcnt_r;
  logic [7:0] shreg_r;
  logic [7:0] byte_in;
  logic [7:0] tx_r;
  logic [7:0] rd_byte;
  logic ack_r;
  logic oe_r;
  logic rd_r;
  logic sys_r;
  logic first_r;
  logic wd_ok_r;
  logic [ADR_W-1:0] addr_r;
  logic [ADR_W-1:0] next_addr;
  logic [PAGE_W-1:0] pcnt_r;
  logic [PAGE_W-1:0] pidx;
  logic [PAGE_W-1:0] last_lo;
  logic [(1<<PAGE_W)-1:0] pmask_r;
  logic [7:0] pbuf [0:(1<<PAGE_W)-1];
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  logic [CNT_W-1:0] tmo_r;
  logic [CNT_W-1:0] wcnt_r;
  logic locked;
  logic sel_ok;
  logic timeout;
  logic wdone;

  // Both lines cross from the pin domain through two flops each.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], bus.scl};
      sda_sync_r <= {sda_sync_r[0], bus.sda};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  assign scl_s = scl_sync_r[1];
  assign sda_s = sda_sync_r[1];
  assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign rise_ev = scl_s & ~scl_d_r;
  assign fall_ev = ~scl_s & scl_d_r;

  assign byte_in = {shreg_r[6:0], sda_s};
  assign sel_ok = (byte_in[SEL_TYPE_LSB +: 4] == DEV_TYPE) &&
                  (byte_in[SEL_CE_LSB +: 2] == CE_FIXED);
  assign locked = sector_lock_i[addr_r[SECT_LSB +: SECT_W]] & ~key_ok_i;
  assign pidx = addr_r[PAGE_W-1:0] + pcnt_r;
  assign last_lo = addr_r[PAGE_W-1:0] + pcnt_r - 2'h1;
  assign next_addr = {addr_r[ADR_W-1:PAGE_W], last_lo} + 16'h0001;
  // System area content is not held here; it reads as erased.
  assign rd_byte = sys_r ? ERASED : mem[addr_r[MEM_AW-1:0]];
  assign timeout = tmo_r >= (first_r ? CNT_W'(START_TMO) : CNT_W'(CLK_TMO));
  assign wdone = (slot_r == S_WCYC) && (wcnt_r == CNT_W'(WCYC - 1));

  // Phase watchdog; while no rise has followed Start the start limit applies.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmo_r <= '0;
    end else if (slot_r == S_IDLE || slot_r == S_WCYC || start_ev || rise_ev) begin
      tmo_r <= '0;
    end else if (fall_ev && !first_r) begin
      tmo_r <= '0;
    end else if (tmo_r != '1) begin
      tmo_r <= tmo_r + 16'h0001;
    end
  end

  // Self-timed write cycle length.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wcnt_r <= '0;
    end else if (slot_r != S_WCYC) begin
      wcnt_r <= '0;
    end else begin
      wcnt_r <= wcnt_r + 16'h0001;
    end
  end

  // Page latch commits to the array only at the end of the write cycle.
  always_ff @(posedge clk_i) begin
    if (wdone) begin
      for (int i = 0; i < (1 << PAGE_W); i++) begin
        if (pmask_r[i]) begin
          mem[{addr_r[MEM_AW-1:PAGE_W], PAGE_W'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // Byte engine.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_r <= S_IDLE;
      bitcnt_r <= '0;
      shreg_r <= '0;
      tx_r <= ERASED;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
      rd_r <= 1'b0;
      sys_r <= 1'b0;
      first_r <= 1'b0;
      wd_ok_r <= 1'b0;
      addr_r <= '0;
      pcnt_r <= '0;
      pmask_r <= '0;
    end else if (slot_r == S_WCYC) begin
      oe_r <= 1'b0;
      if (wdone) begin
        slot_r <= S_IDLE;
        addr_r <= next_addr;
      end
    end else if (start_ev) begin
      slot_r <= S_SEL;
      bitcnt_r <= '0;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
      first_r <= 1'b1;
      wd_ok_r <= 1'b0;
      pcnt_r <= '0;
      pmask_r <= '0;
    end else if (stop_ev) begin
      oe_r <= 1'b0;
      ack_r <= 1'b0;
      // Programming only for a Stop in the tenth slot after an acked data byte.
      // The clock rise ahead of a Stop has already been counted as one bit.
      if (slot_r == S_WD && bitcnt_r == BITS_SLOT - BITS_BYTE && wd_ok_r && pmask_r != '0) begin
        slot_r <= S_WCYC;
      end else begin
        slot_r <= S_IDLE;
      end
    end else if (slot_r != S_IDLE && timeout) begin
      slot_r <= S_IDLE;
      oe_r <= 1'b0;
      ack_r <= 1'b0;
    end else if (slot_r != S_IDLE && rise_ev) begin
      first_r <= 1'b0;
      if (bitcnt_r < BITS_BYTE) begin
        shreg_r <= byte_in;
        bitcnt_r <= bitcnt_r + 4'h1;
        if (bitcnt_r == BITS_BYTE - 4'h1) begin
          unique case (slot_r)
            S_SEL: begin
              if (sel_ok) begin
                ack_r <= 1'b1;
                rd_r <= byte_in[SEL_RW];
                sys_r <= byte_in[SEL_UPCE];
              end else begin
                slot_r <= S_IDLE;
              end
            end
            S_AH: begin
              ack_r <= 1'b1;
              addr_r[ADR_W-1:8] <= byte_in;
            end
            S_AL: begin
              ack_r <= 1'b1;
              addr_r[7:0] <= byte_in;
            end
            S_WD: begin
              pcnt_r <= pcnt_r + 2'h1;
              if (!locked && !sys_r) begin
                ack_r <= 1'b1;
                pbuf[pidx] <= byte_in;
                pmask_r[pidx] <= 1'b1;
              end else begin
                ack_r <= 1'b0;
              end
            end
            S_RD: begin
              ack_r <= 1'b0;
            end
            S_IDLE, S_WCYC: begin
              ack_r <= 1'b0;
            end
          endcase
        end
      end else begin
        bitcnt_r <= BITS_SLOT;
        wd_ok_r <= (slot_r == S_WD) && ack_r;
        if (slot_r == S_RD && sda_s) begin
          slot_r <= S_IDLE;
        end
      end
    end else if (slot_r != S_IDLE && fall_ev) begin
      wd_ok_r <= wd_ok_r && (bitcnt_r == BITS_SLOT);
      if (bitcnt_r == BITS_BYTE) begin
        oe_r <= ack_r;
      end else if (bitcnt_r == BITS_SLOT) begin
        bitcnt_r <= '0;
        ack_r <= 1'b0;
        oe_r <= 1'b0;
        unique case (slot_r)
          S_SEL: slot_r <= rd_r ? S_RD : S_AH;
          S_AH: slot_r <= S_AL;
          S_AL: slot_r <= S_WD;
          default: slot_r <= slot_r;
        endcase
        if (slot_r == S_RD || (slot_r == S_SEL && rd_r)) begin
          // Fetch and advance before the first data bit goes out.
          tx_r <= {rd_byte[6:0], 1'b1};
          oe_r <= ~rd_byte[7];
          addr_r <= addr_r + 16'h0001;
        end
      end else if (slot_r == S_RD && bitcnt_r != '0) begin
        oe_r <= ~tx_r[7];
        tx_r <= {tx_r[6:0], 1'b1};
      end
    end
  end

  // The line is only ever pulled low, never driven high.
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = oe_r;
  assign rf_block_o = slot_r != S_IDLE;
  assign wip_o = slot_r == S_WCYC;
endmodule
`default_nettype wire

/* File: two_wire_master.sv */
// Purpose: Bus master end that issues Start, Stop and byte transfers ordered over Wishbone.
// Assumes: One command at a time; software polls the busy flag.
// Notes: The clock is divided from clk_i; no clock stretching is honoured.
`timescale 1ns/1ns
`default_nettype none
module two_wire_master
  import eeprom_serial_pkg::*;
#(
  parameter int QUARTER = QUARTER_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [WB_AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  two_wire_if.master bus
);
  hstate_e hs_r;
  logic [1:0] sda_sync_r;
  logic [CNT_W-1:0] qcnt_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [7:0] txsh_r;
  logic [7:0] rx_r;
  logic rd_r;
  logic nack_r;
  logic ackseen_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic ack_r;
  logic tick;
  logic take;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_sync_r <= 2'h3;
    end else begin
      sda_sync_r <= {sda_sync_r[0], bus.sda};
    end
  end

  assign tick = qcnt_r == CNT_W'(QUARTER - 1);
  assign take = cyc_i && stb_i && !ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || hs_r == H_IDLE || tick) begin
      qcnt_r <= '0;
    end else begin
      qcnt_r <= qcnt_r + 16'h0001;
    end
  end

  // Wishbone slave: one wait state, ack for one cycle, unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_r <= take;
      if (take && !we_i && adr_i == WB_STAT) begin
        dat_o <= {16'h0000, rx_r, 6'h00, ackseen_r, hs_r != H_IDLE};
      end else if (take) begin
        dat_o <= '0;
      end
    end
  end

  assign ack_o = ack_r;

  // Bit engine in four quarters: set data, raise clock, sample, lower clock.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_r <= H_IDLE;
      q_r <= '0;
      bit_r <= '0;
      txsh_r <= '0;
      rx_r <= '0;
      rd_r <= 1'b0;
      nack_r <= 1'b0;
      ackseen_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (hs_r == H_IDLE) begin
      q_r <= '0;
      bit_r <= '0;
      // Writes of a command while busy are dropped.
      if (take && we_i && adr_i == WB_CMD && sel_i[0] && sel_i[1]) begin
        txsh_r <= dat_i[7:0];
        nack_r <= dat_i[CMD_NACK];
        rd_r <= dat_i[CMD_OP_LSB +: 3] == CMD_READ;
        unique case (dat_i[CMD_OP_LSB +: 3])
          CMD_START: hs_r <= H_START;
          CMD_STOP: hs_r <= H_STOP;
          CMD_WRITE, CMD_READ: hs_r <= H_BIT;
          default: hs_r <= H_IDLE;
        endcase
      end
    end else if (tick) begin
      q_r <= q_r + 2'h1;
      unique case (hs_r)
        H_START: begin
          unique case (q_r)
            2'h0: sda_oe_r <= 1'b0;
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b1;
            2'h3: begin
              scl_oe_r <= 1'b1;
              hs_r <= H_IDLE;
            end
          endcase
        end
        H_STOP: begin
          unique case (q_r)
            2'h0: sda_oe_r <= 1'b1;
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b0;
            2'h3: hs_r <= H_IDLE;
          endcase
        end
        default: begin
          unique case (q_r)
            2'h0: begin
              // Data changes only while the clock is low.
              if (bit_r < BITS_BYTE) begin
                sda_oe_r <= !rd_r && !txsh_r[7];
              end else begin
                sda_oe_r <= rd_r && !nack_r;
              end
            end
            2'h1: scl_oe_r <= 1'b0;
            2'h2: begin
              if (bit_r < BITS_BYTE) begin
                rx_r <= {rx_r[6:0], sda_sync_r[1]};
              end else begin
                ackseen_r <= !sda_sync_r[1];
              end
            end
            2'h3: begin
              scl_oe_r <= 1'b1;
              txsh_r <= {txsh_r[6:0], 1'b0};
              bit_r <= bit_r + 4'h1;
              if (bit_r == BITS_BYTE) begin
                hs_r <= H_IDLE;
              end
            end
          endcase
        end
      endcase
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_r;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_oe_r;
endmodule
`default_nettype wire

/* File: eeprom_serial_slave_port_properties.sv */
// Purpose: Concurrent checks on the two-wire link between master and memory port.
// Assumes: All lines are sampled on clk_i; rst_i is synchronous and active high.
// Notes: Slack of a few cycles covers the port's two-flop line synchronisers.
`timescale 1ns/1ns
`default_nettype none
module eeprom_serial_slave_port_properties #(
  parameter int CLK_TMO = 1000,
  parameter int WCYC = 2000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe,
  input wire logic rf_block_o,
  input wire logic wip_o
);
  localparam int LIM = CLK_TMO + 16;
  int ph_r;
  int from_start_r;
  int from_stop_r;
  int wlen_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    if (rst_i || $changed(scl)) begin
      ph_r <= 0;
    end else if (ph_r < LIM) begin
      ph_r <= ph_r + 1;
    end
  end
  // Counters saturate so that a long idle bus never wraps them back into range.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      from_start_r <= 1000;
    end else if ($fell(sda) && scl && $past(scl)) begin
      from_start_r <= 0;
    end else if (from_start_r < 1000) begin
      from_start_r <= from_start_r + 1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      from_stop_r <= 1000;
    end else if ($rose(sda) && scl && $past(scl)) begin
      from_stop_r <= 0;
    end else if (from_stop_r < 1000) begin
      from_stop_r <= from_stop_r + 1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !wip_o) begin
      wlen_r <= 0;
    end else begin
      wlen_r <= wlen_r + 1;
    end
  end
  property p_wip_rf;
    wip_o |-> rf_block_o;
  endproperty
  a_wip_rf: assert property (p_wip_rf) else $error("write cycle without radio block");
  property p_wip_quiet;
    wip_o |-> !s_sda_oe;
  endproperty
  a_wip_quiet: assert property (p_wip_quiet) else $error("data driven in write cycle");
  property p_drive_in_op;
    $rose(s_sda_oe) |-> rf_block_o;
  endproperty
  a_drive_in_op: assert property (p_drive_in_op) else $error("data driven in standby");
  property p_wip_len;
    $fell(wip_o) |-> (wlen_r >= WCYC - 2) && (wlen_r <= WCYC + 2);
  endproperty
  a_wip_len: assert property (p_wip_len) else $error("write cycle length wrong");
  property p_start_wakes;
    $rose(rf_block_o) |-> from_start_r <= 12;
  endproperty
  a_start_wakes: assert property (p_start_wakes) else $error("woke without start");
  property p_stop_ends;
    $rose(sda) && scl && $past(scl) |-> ##[1:12] (!rf_block_o || wip_o);
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("stop did not end transfer");
  property p_phase_tmo;
    ph_r == LIM |-> !rf_block_o || wip_o;
  endproperty
  a_phase_tmo: assert property (p_phase_tmo) else $error("clock timeout ignored");
  property p_wip_after_stop;
    $rose(wip_o) |-> from_stop_r <= 12;
  endproperty
  a_wip_after_stop: assert property (p_wip_after_stop) else $error("write without stop");
endmodule
`default_nettype wire

/* File: eeprom_serial_slave_port_tb_top.sv */
// Purpose: Drives the bus master over Wishbone against the memory port and judges the results.
// Assumes: Short timeouts and write time are set so the run stays brief.
// Notes: The master's status register reports the ninth-slot acknowledge seen.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module eeprom_serial_slave_port_tb_top import eeprom_serial_pkg::*;;
  localparam int TMO = 200;
  localparam int WCYC = 400;
  localparam int LIMIT = 60000;
  localparam logic [7:0] SEL_W = {DEV_TYPE_DEF, 1'b0, CE_FIXED, 1'b0};
  localparam logic [7:0] SEL_R = {DEV_TYPE_DEF, 1'b0, CE_FIXED, 1'b1};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [WB_AW-1:0] wb_adr = '0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dw = 32'h0;
  logic [31:0] wb_dr;
  logic wb_ack;
  logic [SECT_N-1:0] lock = '0;
  logic key_ok = 1'b0;
  logic rf_block;
  logic wip;
  int bad_count = 0;
  int n_checks = 0;
  int tick = 0;
  two_wire_if two_wire_if_i();
  two_wire_master two_wire_master_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(wb_cyc),
    .stb_i(wb_stb), .we_i(wb_we), .adr_i(wb_adr), .sel_i(wb_sel), .dat_i(wb_dw),
    .dat_o(wb_dr), .ack_o(wb_ack), .bus(two_wire_if_i));
  eeprom_serial_slave_port #(.START_TMO(TMO), .CLK_TMO(TMO), .WCYC(WCYC))
    eeprom_serial_slave_port_i (.clk_i(clk_i), .rst_i(rst_i), .bus(two_wire_if_i),
    .sector_lock_i(lock), .key_ok_i(key_ok), .rf_block_o(rf_block), .wip_o(wip));
  eeprom_serial_slave_port_properties #(.CLK_TMO(TMO), .WCYC(WCYC))
    eeprom_serial_slave_port_properties_i (.clk_i(clk_i), .rst_i(rst_i),
    .scl(two_wire_if_i.scl), .sda(two_wire_if_i.sda), .s_sda_oe(two_wire_if_i.s_sda_oe),
    .rf_block_o(rf_block), .wip_o(wip));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    tick++;
    if (tick == LIMIT) begin
      bad_count++;
      conclude();
    end
  end
  task automatic wb(input logic w, input logic [WB_AW-1:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_dw <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_dr;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // Every command is followed by busy polling, so no byte overlaps the next.
  task automatic cmd(input logic [2:0] op, input logic [7:0] b, input logic nk,
                     output logic [31:0] res);
    wb(1'b1, WB_CMD, {20'h0, nk, op, b}, res);
    do begin
      wb(1'b0, WB_STAT, 32'h0, res);
    end while (res[STAT_BUSY] !== 1'b0);
  endtask
  task automatic bare(input logic [2:0] op);
    logic [31:0] res;
    cmd(op, 8'h00, 1'b0, res);
  endtask
  task automatic txc(input logic [7:0] b, input logic e);
    logic [31:0] res;
    cmd(CMD_WRITE, b, 1'b0, res);
    `CHK("ack", e, res[STAT_ACK])
  endtask
  task automatic rdc(input logic nk, input logic [7:0] e);
    logic [31:0] res;
    cmd(CMD_READ, 8'h00, nk, res);
    `CHK("rx", e, res[STAT_RX_LSB +: 8])
  endtask
  task automatic addr_w(input logic [15:0] a);
    bare(CMD_START);
    txc(SEL_W, 1'b1);
    txc(a[15:8], 1'b1);
    txc(a[7:0], 1'b1);
  endtask
  task automatic wwip(input logic v, input int lim);
    int n;
    n = 0;
    while (wip !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic t_page;
    addr_w(16'h0010);
    for (int i = 0; i < 4; i++) begin
      txc(8'(8'h11 * (i + 1)), 1'b1);
    end
    bare(CMD_STOP);
    wwip(1'b1, 40);
    `CHK("wip", 1'b1, wip)
    bare(CMD_START);
    txc(SEL_W, 1'b0);
    bare(CMD_STOP);
    wwip(1'b0, 2000);
    addr_w(16'h000F);
    txc(8'h5A, 1'b1);
    bare(CMD_STOP);
    wwip(1'b1, 40);
    wwip(1'b0, 2000);
    bare(CMD_START);
    txc(SEL_R, 1'b1);
    rdc(1'b0, 8'h11);
    rdc(1'b0, 8'h22);
    rdc(1'b1, 8'h33);
    bare(CMD_STOP);
    `CHK("rf_block", 1'b0, rf_block)
    addr_w(16'h000F);
    bare(CMD_START);
    txc(SEL_R, 1'b1);
    rdc(1'b1, 8'h5A);
    bare(CMD_STOP);
    $display("t_page done");
  endtask
  task automatic t_lock;
    lock[0] <= 1'b1;
    addr_w(16'h0030);
    txc(8'h77, 1'b0);
    bare(CMD_STOP);
    wwip(1'b1, 40);
    `CHK("wip", 1'b0, wip)
    key_ok <= 1'b1;
    addr_w(16'h0030);
    txc(8'h77, 1'b1);
    bare(CMD_STOP);
    wwip(1'b1, 40);
    `CHK("wip", 1'b1, wip)
    wwip(1'b0, 2000);
    lock[0] <= 1'b0;
    key_ok <= 1'b0;
    $display("t_lock done");
  endtask
  task automatic t_sel;
    bare(CMD_START);
    txc(SEL_W ^ 8'h80, 1'b0);
    txc(SEL_W, 1'b0);
    bare(CMD_STOP);
    addr_w(16'h0040);
    bare(CMD_STOP);
    wwip(1'b1, 40);
    `CHK("wip", 1'b0, wip)
    bare(CMD_START);
    txc(SEL_W | 8'h08, 1'b1);
    txc(8'h00, 1'b1);
    txc(8'h20, 1'b1);
    txc(8'h00, 1'b0);
    bare(CMD_START);
    txc(SEL_R | 8'h08, 1'b1);
    rdc(1'b1, ERASED);
    bare(CMD_STOP);
    $display("t_sel done");
  endtask
  // Both waits outlast the device limits on purpose; the master breaks its own rule here.
  task automatic t_tmo;
    bare(CMD_START);
    repeat (TMO + 50) @(posedge clk_i);
    txc(SEL_W, 1'b0);
    bare(CMD_STOP);
    bare(CMD_START);
    txc(SEL_W, 1'b1);
    repeat (TMO + 50) @(posedge clk_i);
    txc(8'h00, 1'b0);
    bare(CMD_STOP);
    $display("t_tmo done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_page();
    t_lock();
    t_sel();
    t_tmo();
    conclude();
  end
endmodule
`default_nettype wire
